// >>> design/mapc_pkg.sv
// constants for the mode, address-width and shared-pin configuration block
// What this block does
// - modes 1 and 3: shared low pins start as port pins; software may change
// - modes 2 and 4: shared low pins start as low data bus; software may change
// - 1-Mbyte modes form 20-bit addresses, upper 4 bits dropped
// - normal processor mode limits addresses to 64 kilobytes
// - advanced processor mode reaches up to 16 megabytes
// - only advanced processor mode exists; normal mode cannot be selected
package mapc_pkg;
   localparam int MODE_W = 3;
   localparam int ADDR_W = 24;
   localparam int PINS_W = 8;
   localparam int SYNC_STAGES = 2;
   localparam logic [MODE_W-1:0] MODE_1 = 3'h1;
   localparam logic [MODE_W-1:0] MODE_2 = 3'h2;
   localparam logic [MODE_W-1:0] MODE_3 = 3'h3;
   localparam logic [MODE_W-1:0] MODE_4 = 3'h4;
   localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
   localparam logic [ADDR_W-1:0] MASK_1M = 24'h0FFFFF;
   localparam logic [ADDR_W-1:0] MASK_16M = 24'hFFFFFF;
   localparam logic [ADDR_W-1:0] MASK_64K = 24'h00FFFF;
   localparam logic [PINS_W-1:0] PINS_PORT = 8'h00;
   localparam logic [PINS_W-1:0] PINS_DATA = 8'hFF;
   localparam logic [1:0] SETTLE_CNT = 2'h2;
   typedef enum logic [1:0] {MAPC_WAIT, MAPC_RUN} mapc_state_e;
endpackage

// >>> design/mapc_sync.sv
// two-flop synchroniser for the mode-select pins
`timescale 1ns/1ps
`default_nettype none
module mapc_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } mapc_sync_s;
   mapc_sync_s st_r;
   mapc_sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = d;
      // first stage is read by the second stage only
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.sync;
endmodule
`default_nettype wire

// >>> design/mapc_top.sv
// mode latch, shared low pin function select and effective address width
`timescale 1ns/1ps
`default_nettype none
module mapc_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // mode pins, asynchronous
   input wire logic [mapc_pkg::MODE_W-1:0] mode_pins,
   // processor mode request, ignored on this device
   input wire logic normal_mode_req,
   // software override of shared low pin function, 1 = data bus
   input wire logic pin_func_wr,
   input wire logic [mapc_pkg::PINS_W-1:0] pin_func_data,
   // address from processor
   input wire logic [mapc_pkg::ADDR_W-1:0] cpu_addr,
   // configuration outputs
   output logic mode_valid,
   output logic mode_bad,
   output logic [mapc_pkg::MODE_W-1:0] mode_latched,
   output logic cpu_advanced,
   output logic wide_addr,
   output logic [mapc_pkg::PINS_W-1:0] low_port_pins_data_sel,
   output logic [mapc_pkg::ADDR_W-1:0] eff_addr
);
   typedef struct packed {
      mapc_pkg::mapc_state_e state;
      logic [1:0] settle;
      logic [mapc_pkg::MODE_W-1:0] mode;
      logic bad;
      logic advanced;
      logic [mapc_pkg::PINS_W-1:0] data_sel;
      logic [mapc_pkg::ADDR_W-1:0] mask;
      logic [mapc_pkg::ADDR_W-1:0] addr;
   } mapc_top_s;

   mapc_top_s st_r;
   mapc_top_s st_nxt;
   logic [mapc_pkg::MODE_W-1:0] mode_sync;

   mapc_sync #(
      .WIDTH(mapc_pkg::MODE_W)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(mode_pins),
      .q(mode_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      // normal mode request has no effect: advanced only
      st_nxt.advanced = 1'b1;
      case (st_r.state)
         mapc_pkg::MAPC_WAIT: begin
            // wait until the synchroniser holds post-release pin values
            if (st_r.settle != mapc_pkg::SETTLE_CNT) begin
               st_nxt.settle = st_r.settle + 2'h1;
            end else begin
               st_nxt.state = mapc_pkg::MAPC_RUN;
               st_nxt.mode = mode_sync;
               st_nxt.bad = 1'b0;
               case (mode_sync)
                  mapc_pkg::MODE_1: begin
                     st_nxt.data_sel = mapc_pkg::PINS_PORT;
                     st_nxt.mask = mapc_pkg::MASK_1M;
                  end
                  mapc_pkg::MODE_3: begin
                     st_nxt.data_sel = mapc_pkg::PINS_PORT;
                     st_nxt.mask = mapc_pkg::MASK_16M;
                  end
                  mapc_pkg::MODE_2: begin
                     st_nxt.data_sel = mapc_pkg::PINS_DATA;
                     st_nxt.mask = mapc_pkg::MASK_1M;
                  end
                  mapc_pkg::MODE_4: begin
                     st_nxt.data_sel = mapc_pkg::PINS_DATA;
                     st_nxt.mask = mapc_pkg::MASK_16M;
                  end
                  default: begin
                     // unsupported strap: safest is narrow, port pins
                     st_nxt.bad = 1'b1;
                     st_nxt.data_sel = mapc_pkg::PINS_PORT;
                     st_nxt.mask = mapc_pkg::MASK_1M;
                  end
               endcase
            end
         end
         mapc_pkg::MAPC_RUN: begin
            // mode stays frozen until the next reset
            if (pin_func_wr) begin
               st_nxt.data_sel = pin_func_data;
            end
         end
         default: begin
            st_nxt.state = mapc_pkg::MAPC_WAIT;
         end
      endcase
      // normal mode would cap at 64k; kept for a part that offers it
      if (!st_nxt.advanced) begin
         st_nxt.mask = mapc_pkg::MASK_64K;
      end
      st_nxt.addr = cpu_addr & st_r.mask;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.state <= mapc_pkg::MAPC_WAIT;
         st_r.settle <= 2'h0;
         st_r.mode <= mapc_pkg::MODE_RST;
         st_r.bad <= 1'b0;
         st_r.advanced <= 1'b1;
         st_r.data_sel <= mapc_pkg::PINS_PORT;
         st_r.mask <= mapc_pkg::MASK_1M;
         st_r.addr <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign mode_valid = (st_r.state == mapc_pkg::MAPC_RUN);
   assign mode_bad = st_r.bad;
   assign mode_latched = st_r.mode;
   assign cpu_advanced = st_r.advanced;
   assign wide_addr = (st_r.mask == mapc_pkg::MASK_16M);
   assign low_port_pins_data_sel = st_r.data_sel;
   assign eff_addr = st_r.addr;

   // request pin kept only so the port list matches a normal-capable part
   logic unused_req;
   assign unused_req = normal_mode_req;
endmodule
`default_nettype wire

// >>> verification/mapc_top_assertions.sv
// checker for the mode and address configuration block
`timescale 1ns/1ps
`default_nettype none
module mapc_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched ports
   input wire logic pin_func_wr,
   input wire logic [7:0] pin_func_data,
   input wire logic [23:0] cpu_addr,
   input wire logic mode_valid,
   input wire logic [2:0] mode_latched,
   input wire logic cpu_advanced,
   input wire logic wide_addr,
   input wire logic [7:0] low_port_pins_data_sel,
   input wire logic [23:0] eff_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_PORT: assert property ($rose(mode_valid) && mode_latched[0] |->
      low_port_pins_data_sel == 8'h00) else $error("pin default");
   AST_DATA: assert property ($rose(mode_valid) && mode_latched inside {3'h2, 3'h4} |->
      low_port_pins_data_sel == 8'hFF) else $error("pin default");
   AST_SW: assert property (mode_valid && pin_func_wr |=>
      low_port_pins_data_sel == $past(pin_func_data)) else $error("pin write");
   AST_MASK: assert property (mode_valid && !wide_addr |=>
      eff_addr == ($past(cpu_addr) & 24'h0FFFFF)) else $error("narrow addr");
   AST_WIDE: assert property (wide_addr |=> eff_addr == $past(cpu_addr)) else $error("wide");
   AST_WIDTH: assert property (mode_valid |->
      wide_addr == (mode_latched inside {3'h3, 3'h4})) else $error("width");
   AST_ADV: assert property (cpu_advanced) else $error("normal mode");
   AST_HOLD: assert property (mode_valid |=> mode_valid && $stable(mode_latched))
      else $error("mode moved");
   cover property ($rose(mode_valid) && low_port_pins_data_sel == 8'hFF);
   cover property ($rose(mode_valid) && wide_addr);
   cover property (mode_valid && pin_func_wr);
endmodule
bind mapc_top mapc_chk mapc_chk_inst (.*);
`default_nettype wire

// >>> verification/mapc_top_tb.sv
// self-checking bench for the mode and address configuration block
`timescale 1ns/1ps
`default_nettype none
module mapc_top_tb;
   logic clk, rst_n, normal_mode_req, pin_func_wr, mode_valid, mode_bad, cpu_advanced, wide_addr;
   logic [2:0] mode_pins, mode_latched;
   logic [7:0] pin_func_data, low_port_pins_data_sel;
   logic [23:0] cpu_addr, eff_addr;
   int n_mismatch = 0, comparisons = 0, sel, mask, a;
   int q[$];
   mapc_top mapc_top_inst (.clk(clk), .rst_n(rst_n), .mode_pins(mode_pins),
      .normal_mode_req(normal_mode_req), .pin_func_wr(pin_func_wr),
      .pin_func_data(pin_func_data), .cpu_addr(cpu_addr), .mode_valid(mode_valid),
      .mode_bad(mode_bad), .mode_latched(mode_latched), .cpu_advanced(cpu_advanced),
      .wide_addr(wide_addr), .low_port_pins_data_sel(low_port_pins_data_sel),
      .eff_addr(eff_addr));
   task check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////
   initial begin
      {rst_n, normal_mode_req, pin_func_wr, mode_pins, pin_func_data, cpu_addr} = '0;
      a = $urandom(42637);
      // every strap, each with its own reset; invalid ones too
      for (int m = 0; m < 8; m++) begin
         @(posedge clk);
         rst_n <= 0;
         pin_func_wr <= 0;
         mode_pins <= 3'(m);
         repeat (2) @(posedge clk);
         rst_n <= 1;
         for (int i = 0; i < 9 && mode_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
         end
         if (mode_valid !== 1'b1) begin
            n_mismatch++;
            break;
         end
         sel = (m == 2 || m == 4) ? 8'hFF : 8'h00;
         mask = (m == 3 || m == 4) ? 24'hFFFFFF : 24'h0FFFFF;
         check(24'(mode_latched), 24'(m));
         check(24'(mode_bad), 24'(m == 0 || m > 4));
         check(24'(wide_addr), 24'(mask[23]));
         check(24'(cpu_advanced), 24'h000001);
         q = {};
         // strap wiggles here must not disturb the latched mode
         for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            a = $urandom;
            cpu_addr <= a[23:0];
            pin_func_wr <= a[24];
            normal_mode_req <= a[25];
            mode_pins <= a[28:26];
            pin_func_data <= 8'(a >> 24);
            #1;
            check(24'(low_port_pins_data_sel), 24'(sel));
            if (i > 0) check(eff_addr, 24'(q.pop_front() & mask));
            q.push_back(a);
            if (a[24]) sel = a[31:24];
         end
         check(24'(mode_latched), 24'(m));
      end
      finish_test;
   end
endmodule
`default_nettype wire
